// [hw/ctm_timer.sv]
// module: cascaded 16-bit timer with event, pwm and pulse generator modes
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns

module ctm_timer (
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        count_input_pin,
    output logic             pwm_output_pin,
    output logic             pulse_gen_output_pin,
    output logic             period_interrupt
);
    import ctm_pkg::*;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic                 run_bit_q;
    logic                 flipflop_preset_bit_q;
    ctm_mode_t            mode_q;
    logic [2:0]           src_q;
    logic [15:0]          period_q;
    logic [15:0]          duty_active_q;
    logic [15:0]          duty_shadow_q;
    logic                 duty_pending_q;
    logic [7:0]           count_low_q;
    logic [7:0]           count_high_q;
    logic                 output_flipflop_q;
    logic                 irq_sticky_q;
    logic                 irq_pulse_q;
    logic                 pwm_pin_q;
    logic                 pgen_pin_q;
    logic [31:0]          prdata_q;
    logic                 pready_q;
    logic                 pslverr_q;

    logic                 wr_en;
    logic                 rd_en;
    logic                 addr_ok;
    logic                 tick;
    logic [15:0]          count;
    logic                 low_carry;
    logic                 overflow;
    logic                 duty_hit;
    logic                 period_hit;
    logic                 wrap;
    logic                 toggle;
    logic [31:0]          rd_d;

    ctm_tick_if tk ();

    assign tk.run = run_bit_q;
    assign tk.src = src_q;
    assign tick   = tk.tick;

    ctm_tick_sel u_tick (
        .core_clk        (core_clk),
        .reset_n         (reset_n),
        .count_input_pin (count_input_pin),
        .tk              (tk)
    );

    // ------------------------------------------------------------
    // apb slave: setup phase then access with one wait cycle, answer next edge
    // ------------------------------------------------------------
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == CTM_OFF_CTRL) || (a == CTM_OFF_PERIOD) || (a == CTM_OFF_DUTY)
                 || (a == CTM_OFF_COUNT) || (a == CTM_OFF_STATUS);
    endfunction : is_mapped

    // writes are taken in the cycle pready is high, reads one cycle earlier, so each access is one wait cycle
    assign addr_ok = is_mapped(paddr);
    assign wr_en   = psel && penable && pready_q && pwrite && addr_ok;
    assign rd_en   = psel && penable && !pready_q && !pwrite;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !addr_ok;
        end
    end

    always_comb begin
        rd_d = 32'h0000_0000;
        case (paddr)
            CTM_OFF_CTRL: begin
                rd_d[CTM_CTRL_RUN_POS]    = run_bit_q;
                rd_d[CTM_CTRL_PRESET_POS] = flipflop_preset_bit_q;
                rd_d[CTM_CTRL_MODE_POS +: 2] = mode_q;
                rd_d[CTM_CTRL_SRC_POS +: CTM_CTRL_SRC_W] = src_q;
            end
            CTM_OFF_PERIOD: rd_d[15:0] = period_q;
            // a pending pwm write stays invisible until the counter overflow wrap loads it
            CTM_OFF_DUTY: rd_d[15:0] = duty_active_q;
            CTM_OFF_COUNT: rd_d[15:0] = count;
            CTM_OFF_STATUS: begin
                rd_d[CTM_STAT_IRQ_POS] = irq_sticky_q;
                rd_d[CTM_STAT_FF_POS]  = output_flipflop_q;
            end
            default: rd_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            prdata_q <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata_q <= rd_d;
        end
    end

    // ------------------------------------------------------------
    // control and compare registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            run_bit_q             <= CTM_CTRL_RST[CTM_CTRL_RUN_POS];
            flipflop_preset_bit_q <= CTM_CTRL_RST[CTM_CTRL_PRESET_POS];
            mode_q                <= CTM_MODE_EVENT;
            src_q                 <= CTM_CTRL_RST[CTM_CTRL_SRC_POS +: CTM_CTRL_SRC_W];
        end else if (wr_en && paddr == CTM_OFF_CTRL) begin
            run_bit_q             <= pwdata[CTM_CTRL_RUN_POS];
            flipflop_preset_bit_q <= pwdata[CTM_CTRL_PRESET_POS];
            mode_q                <= ctm_mode_t'(pwdata[CTM_CTRL_MODE_POS +: 2]);
            src_q                 <= pwdata[CTM_CTRL_SRC_POS +: CTM_CTRL_SRC_W];
        end
    end

    // no shadow: a new period takes effect at the next compare
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            period_q <= CTM_PERIOD_RST;
        end else if (wr_en && paddr == CTM_OFF_PERIOD) begin
            period_q <= pwdata[15:0];
        end
    end

    // the written value sits in the shadow; in pwm while running it waits for the wrap
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            duty_shadow_q  <= CTM_DUTY_RST;
            duty_pending_q <= 1'b0;
        end else if (wr_en && paddr == CTM_OFF_DUTY) begin
            duty_shadow_q  <= pwdata[15:0];
            duty_pending_q <= (mode_q == CTM_MODE_PWM) && run_bit_q;
        end else if (wrap) begin
            duty_pending_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            duty_active_q <= CTM_DUTY_RST;
        end else if (wr_en && paddr == CTM_OFF_DUTY
                     && !(mode_q == CTM_MODE_PWM && run_bit_q)) begin
            duty_active_q <= pwdata[15:0];
        end else if (wrap && duty_pending_q) begin
            duty_active_q <= duty_shadow_q;
        end
    end

    // ------------------------------------------------------------
    // cascaded counter and compare
    // ------------------------------------------------------------
    assign count     = {count_high_q, count_low_q};
    assign low_carry = tick && (count_low_q == 8'hff);
    assign overflow  = tick && (count == 16'hffff);
    assign duty_hit  = tick && ({count_high_q, count_low_q} + 16'h0001 == duty_active_q);
    assign period_hit = tick && (count + 16'h0001 == period_q);

    always_comb begin
        case (mode_q)
            CTM_MODE_EVENT, CTM_MODE_TIMER: wrap = period_hit;
            CTM_MODE_PWM:   wrap = overflow;
            CTM_MODE_PGEN:  wrap = period_hit;
            default:        wrap = 1'b0;
        endcase
    end

    always_comb begin
        case (mode_q)
            CTM_MODE_PWM, CTM_MODE_PGEN: toggle = duty_hit ^ wrap;
            default:                     toggle = 1'b0;
        endcase
    end

    // stopping clears the count but the flip-flop keeps its level
    always_ff @(posedge core_clk) begin
        if (!reset_n || !run_bit_q) begin
            count_low_q  <= 8'h00;
            count_high_q <= 8'h00;
        end else if (wrap) begin
            count_low_q  <= 8'h00;
            count_high_q <= 8'h00;
        end else if (tick) begin
            count_low_q  <= count_low_q + 8'h01;
            count_high_q <= low_carry ? count_high_q + 8'h01 : count_high_q;
        end
    end

    // ------------------------------------------------------------
    // output flip-flop, pins and interrupt
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            output_flipflop_q <= 1'b0;
        end else if (wr_en && paddr == CTM_OFF_CTRL && !run_bit_q
                     && !pwdata[CTM_CTRL_RUN_POS]) begin
            output_flipflop_q <= pwdata[CTM_CTRL_PRESET_POS];
        end else if (run_bit_q && toggle) begin
            output_flipflop_q <= ~output_flipflop_q;
        end
    end

    // pins follow the inverted flip-flop, so a stop leaves them where they were
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pwm_pin_q  <= 1'b1;
            pgen_pin_q <= 1'b1;
        end else begin
            pwm_pin_q  <= ~output_flipflop_q;
            pgen_pin_q <= ~output_flipflop_q;
        end
    end

    // sticky status: a wrap in the clearing write's cycle wins
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            irq_sticky_q <= 1'b0;
            irq_pulse_q  <= 1'b0;
        end else begin
            irq_pulse_q <= run_bit_q && wrap;
            if (run_bit_q && wrap) begin
                irq_sticky_q <= 1'b1;
            end else if (wr_en && paddr == CTM_OFF_STATUS && pwdata[CTM_STAT_IRQ_POS]) begin
                irq_sticky_q <= 1'b0;
            end
        end
    end

    assign prdata               = prdata_q;
    assign pready               = pready_q;
    assign pslverr              = pslverr_q;
    assign pwm_output_pin       = pwm_pin_q;
    assign pulse_gen_output_pin = pgen_pin_q;
    assign period_interrupt     = irq_pulse_q;

endmodule : ctm_timer

// [hw/ctm_pkg.sv]
// package: register map, field positions, reset values and modes of the cascaded timer
package ctm_pkg;

    // register byte offsets on the apb bus
    localparam logic [7:0] CTM_OFF_CTRL   = 8'h00;
    localparam logic [7:0] CTM_OFF_PERIOD = 8'h04;
    localparam logic [7:0] CTM_OFF_DUTY   = 8'h08;
    localparam logic [7:0] CTM_OFF_COUNT  = 8'h0c;
    localparam logic [7:0] CTM_OFF_STATUS = 8'h10;

    // control register fields
    localparam int CTM_CTRL_RUN_POS    = 0;
    localparam int CTM_CTRL_PRESET_POS = 1;
    localparam int CTM_CTRL_MODE_POS   = 2;
    localparam int CTM_CTRL_SRC_POS    = 4;
    localparam int CTM_CTRL_SRC_W      = 3;

    // status register fields
    localparam int CTM_STAT_IRQ_POS = 0;
    localparam int CTM_STAT_FF_POS  = 1;

    // reset values
    localparam logic [31:0] CTM_CTRL_RST   = 32'h0000_0000;
    localparam logic [15:0] CTM_PERIOD_RST = 16'hffff;
    localparam logic [15:0] CTM_DUTY_RST   = 16'h0000;

    localparam int CTM_CNT_W = 16;
    localparam int CTM_PRE_W = 11;

    // source select codes: divide by 2^11, 2^7, 2^5, 2^3, 2, 1, external pin
    localparam logic [2:0] CTM_SRC_DIV11 = 3'h0;
    localparam logic [2:0] CTM_SRC_DIV7  = 3'h1;
    localparam logic [2:0] CTM_SRC_DIV5  = 3'h2;
    localparam logic [2:0] CTM_SRC_DIV3  = 3'h3;
    localparam logic [2:0] CTM_SRC_DIV1  = 3'h4;
    localparam logic [2:0] CTM_SRC_DIV0  = 3'h5;
    localparam logic [2:0] CTM_SRC_EXT   = 3'h6;

    typedef enum logic [1:0] {
        CTM_MODE_EVENT,
        CTM_MODE_PWM,
        CTM_MODE_PGEN,
        CTM_MODE_TIMER
    } ctm_mode_t;

endpackage : ctm_pkg

// [hw/ctm_tick_if.sv]
// interface: count tick from the clock selector to the counter core
`timescale 1ns/1ns
interface ctm_tick_if;
    logic       tick;
    logic       run;
    logic [2:0] src;
    modport sel (input run, input src, output tick);
    modport core (output run, output src, input tick);
endinterface : ctm_tick_if

// [hw/ctm_tick_sel.sv]
// module: prescaler and external pin edge detector that make the count tick
`timescale 1ns/1ns
module ctm_tick_sel (
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic count_input_pin,
    ctm_tick_if.sel   tk
);
    import ctm_pkg::*;

    logic [CTM_PRE_W-1:0] pre_q;
    logic [CTM_PRE_W-1:0] pre_d;
    logic                 pin_s1_q;
    logic                 pin_s2_q;
    logic                 pin_s3_q;

    assign pre_d = pre_q + {{(CTM_PRE_W-1){1'b0}}, 1'b1};

    // prescaler restarts while stopped so the first period is a full one
    always_ff @(posedge core_clk) begin
        if (!reset_n || !tk.run) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
            pin_s3_q <= 1'b1;
        end else begin
            pin_s1_q <= count_input_pin;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // a carry out of bit n marks one tick every 2^(n+1) clocks
    // the bit index arrives at run time, so a mask replaces a variable part-select
    function automatic logic carry_at(input logic [CTM_PRE_W-1:0] p, input int n);
        logic [CTM_PRE_W-1:0] mask;
        mask     = CTM_PRE_W'((1 << (n + 1)) - 1);
        carry_at = ((p & mask) == mask);
    endfunction : carry_at

    always_comb begin
        case (tk.src)
            CTM_SRC_DIV11: tk.tick = tk.run && carry_at(pre_q, 10);
            CTM_SRC_DIV7:  tk.tick = tk.run && carry_at(pre_q, 6);
            CTM_SRC_DIV5:  tk.tick = tk.run && carry_at(pre_q, 4);
            CTM_SRC_DIV3:  tk.tick = tk.run && carry_at(pre_q, 2);
            CTM_SRC_DIV1:  tk.tick = tk.run && carry_at(pre_q, 0);
            CTM_SRC_DIV0:  tk.tick = tk.run;
            CTM_SRC_EXT:   tk.tick = tk.run && pin_s3_q && !pin_s2_q;
            default:       tk.tick = 1'b0;
        endcase
    end

endmodule : ctm_tick_sel

// [test/ctm_pulse_src.sv]
// partner: external pulse source on the count input pin
`timescale 1ns/1ns
module ctm_pulse_src (
    input  wire logic core_clk,
    output logic      count_input_pin
);
    // ----------------------------------------
    // pulse train, idle high between bursts
    // ----------------------------------------
    localparam int HOLD = 4;

    initial count_input_pin = 1'b1;

    // each level stands HOLD cycles so the input synchroniser never misses one
    task automatic send(input int k);
        repeat (k) begin
            repeat (HOLD) @(posedge core_clk);
            count_input_pin <= 1'b0;
            repeat (HOLD) @(posedge core_clk);
            count_input_pin <= 1'b1;
        end
    endtask : send
endmodule : ctm_pulse_src

// [test/ctm_timer_chk.sv]
// checker: bus handshake, pin and interrupt relations of the cascaded timer
`timescale 1ns/1ns
module ctm_timer_chk
    import ctm_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        reset_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        count_input_pin,
    input wire logic        pwm_output_pin,
    input wire logic        pulse_gen_output_pin,
    input wire logic        period_interrupt
);
    // ----------------------------------------
    // run state seen from bus writes
    // ----------------------------------------
    logic       ctrl_wr;
    logic       run_q;
    logic [1:0] quiet_q;
    assign ctrl_wr = psel && penable && pready && pwrite && (paddr == CTM_OFF_CTRL);
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            run_q <= 1'b0;
        end else if (ctrl_wr) begin
            run_q <= pwdata[CTM_CTRL_RUN_POS];
        end
    end
    // margin of three cycles covers the flip-flop stage and the pin stage
    always_ff @(posedge core_clk) begin
        if (!reset_n || ctrl_wr || run_q) begin
            quiet_q <= 2'h0;
        end else if (quiet_q != 2'h3) begin
            quiet_q <= quiet_q + 2'h1;
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    property p_ready_pulse; pready |=> !pready; endproperty
    property p_ready_after_access; psel && penable && !pready |=> pready; endproperty
    property p_ready_needs_req; pready |-> psel && penable; endproperty
    property p_err_with_ready; pslverr |-> pready; endproperty
    property p_unmapped_rd; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
    property p_irq_pulse; period_interrupt |=> !period_interrupt; endproperty
    property p_pins_equal; pwm_output_pin == pulse_gen_output_pin; endproperty
    property p_hold_stopped; quiet_q == 2'h3 |=> $stable(pwm_output_pin); endproperty
    property p_no_irq_stopped; quiet_q == 2'h3 |-> !period_interrupt; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
    a_ready_after_access: assert property (p_ready_after_access) else $error("pready late");
    a_ready_needs_req: assert property (p_ready_needs_req) else $error("pready without access");
    a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");
    a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read data not zero");
    a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt too long");
    a_pins_equal: assert property (p_pins_equal)
        else $error("output pins differ");
    a_hold_stopped: assert property (p_hold_stopped)
        else $error("pin moved while stopped");
    a_no_irq_stopped: assert property (p_no_irq_stopped)
        else $error("interrupt while stopped");
    c_irq: cover property (period_interrupt);
    c_err: cover property (pready && pslverr);
    c_pin_fall: cover property ($fell(pwm_output_pin));
endmodule : ctm_timer_chk

bind ctm_timer ctm_timer_chk u_ctm_timer_chk (
    .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_input_pin(count_input_pin), .pwm_output_pin(pwm_output_pin),
    .pulse_gen_output_pin(pulse_gen_output_pin), .period_interrupt(period_interrupt)
);

// [test/test_cascaded_16bit_timer_modes.sv]
// testbench: register access, event, pwm and pulse modes of the cascaded timer
`timescale 1ns/1ns
module test_cascaded_16bit_timer_modes;
    import ctm_pkg::*;
    // ----------------------------------------
    // design, partner and clock
    // ----------------------------------------
    logic        core_clk = 1'b0;
    logic        reset_n  = 1'b0;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [7:0]  paddr    = 8'h00;
    logic [31:0] pwdata   = 32'h0;
    logic [31:0] prdata, rd, offs_rst [5];
    logic        pready, pslverr, err, count_input_pin;
    logic        pwm_output_pin, pulse_gen_output_pin, period_interrupt;
    logic [7:0]  offs [5];
    int          failures, n_compared, irq_seen, irq_base, n, k, d, d2, p, w;
    logic        v;
    logic [2:0]  s;

    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) if (period_interrupt === 1'b1) irq_seen <= irq_seen + 1;

    ctm_timer u_ctm_timer (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .count_input_pin(count_input_pin), .pwm_output_pin(pwm_output_pin),
        .pulse_gen_output_pin(pulse_gen_output_pin), .period_interrupt(period_interrupt));
    ctm_pulse_src u_ctm_pulse_src (.core_clk(core_clk), .count_input_pin(count_input_pin));
    // ----------------------------------------
    // tasks and expectation helpers
    // ----------------------------------------
    task automatic report_and_stop();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : report_and_stop
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int t;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        t = 0;
        do begin @(posedge core_clk); t++; end while (pready !== 1'b1 && t < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (t >= 50) begin failures++; report_and_stop(); end
    endtask : apb
    task automatic width(input logic lvl, output int wid);
        int t;
        t = 0;
        while (pwm_output_pin !== lvl && t < 70000) begin @(posedge core_clk); t++; end
        wid = 0;
        while (pwm_output_pin === lvl && wid < 70000) begin @(posedge core_clk); wid++; end
        if (t >= 70000 || wid >= 70000) begin failures++; report_and_stop(); end
    endtask : width
    function automatic logic [31:0] ctl(logic r, logic pr, ctm_mode_t m, logic [2:0] s);
        return (32'(r) << CTM_CTRL_RUN_POS) | (32'(pr) << CTM_CTRL_PRESET_POS) |
               (32'(m) << CTM_CTRL_MODE_POS) | (32'(s) << CTM_CTRL_SRC_POS);
    endfunction : ctl
    // cycles up to the next edge that sees the period interrupt high
    task automatic gap(output int wid);
        wid = 0;
        do begin @(posedge core_clk); wid++; end while (period_interrupt !== 1'b1 && wid < 5000);
        if (wid >= 5000) begin failures++; report_and_stop(); end
    endtask : gap
    function automatic int div_of(input logic [2:0] sc);
        case (sc)
            CTM_SRC_DIV7: return 128;
            CTM_SRC_DIV5: return 32;
            CTM_SRC_DIV3: return 8;
            default:      return 2;
        endcase
    endfunction : div_of
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(64));
        offs = '{CTM_OFF_CTRL, CTM_OFF_PERIOD, CTM_OFF_DUTY, CTM_OFF_COUNT, CTM_OFF_STATUS};
        offs_rst = '{CTM_CTRL_RST, 32'(CTM_PERIOD_RST), 32'(CTM_DUTY_RST), 32'h0, 32'h0};
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        check("pin at reset", 32'(pwm_output_pin), 32'h1);
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, offs[i], 32'h0);
            check("reset value", rd, offs_rst[i]);
        end
        apb(1'b0, 8'h14, 32'h0);
        check("unmapped read", {rd[30:0], err}, 32'h1);
        apb(1'b1, 8'h18, 32'h5a5a_5a5a);
        check("unmapped write", 32'(err), 32'h1);
        // event counting: period wraps counter, remainder left in count
        n = 2 + $urandom % 5;
        k = 5 + $urandom % 16;
        apb(1'b1, CTM_OFF_PERIOD, 32'(n));
        apb(1'b1, CTM_OFF_CTRL, ctl(1'b1, 1'b0, CTM_MODE_EVENT, CTM_SRC_EXT));
        irq_base = irq_seen;
        u_ctm_pulse_src.send(k);
        repeat (10) @(posedge core_clk);
        apb(1'b0, CTM_OFF_COUNT, 32'h0);
        check("event count", rd, 32'(k % n));
        check("event interrupts", 32'(irq_seen - irq_base), 32'(k / n));
        apb(1'b1, CTM_OFF_CTRL, ctl(1'b0, 1'b0, CTM_MODE_EVENT, CTM_SRC_EXT));
        // timer mode on the prescaler: one interrupt every period times divider
        s = 3'(1 + $urandom % 4);
        p = 2 + $urandom % 8;
        apb(1'b1, CTM_OFF_PERIOD, 32'(p));
        apb(1'b1, CTM_OFF_CTRL, ctl(1'b1, 1'b0, CTM_MODE_TIMER, s));
        gap(w);
        gap(w);
        check("timer interval", 32'(w), 32'(p * div_of(s)));
        apb(1'b1, CTM_OFF_CTRL, ctl(1'b0, 1'b0, CTM_MODE_TIMER, s));
        // pwm: immediate load stopped, shadowed load running
        d = 16 + $urandom % 200;
        d2 = 16 + $urandom % 200;
        apb(1'b1, CTM_OFF_DUTY, 32'(d));
        apb(1'b0, CTM_OFF_DUTY, 32'h0);
        check("duty stopped", rd, 32'(d));
        irq_base = irq_seen;
        apb(1'b1, CTM_OFF_CTRL, ctl(1'b1, 1'b0, CTM_MODE_PWM, CTM_SRC_DIV0));
        apb(1'b1, CTM_OFF_DUTY, 32'(d2));
        apb(1'b0, CTM_OFF_DUTY, 32'h0);
        check("duty running", rd, 32'(d));
        width(1'b0, w);
        check("pwm low width", 32'(w), 32'(65536 - d));
        check("pwm interrupts", 32'(irq_seen - irq_base), 32'h1);
        apb(1'b0, CTM_OFF_DUTY, 32'h0);
        check("duty loaded", rd, 32'(d2));
        apb(1'b1, CTM_OFF_CTRL, ctl(1'b0, 1'b0, CTM_MODE_PGEN, CTM_SRC_DIV0));
        // pulse generator: preset, widths, hold on stop
        d = 2 + $urandom % 20;
        p = d + 3 + $urandom % 20;
        apb(1'b1, CTM_OFF_PERIOD, 32'(p));
        apb(1'b1, CTM_OFF_DUTY, 32'(d));
        apb(1'b1, CTM_OFF_CTRL, ctl(1'b0, 1'b1, CTM_MODE_PGEN, CTM_SRC_DIV0));
        apb(1'b1, CTM_OFF_STATUS, 32'h1);
        apb(1'b0, CTM_OFF_STATUS, 32'h0);
        check("preset flip-flop", rd, 32'h2);
        check("preset pin", 32'(pulse_gen_output_pin), 32'h0);
        apb(1'b1, CTM_OFF_CTRL, ctl(1'b0, 1'b0, CTM_MODE_PGEN, CTM_SRC_DIV0));
        apb(1'b1, CTM_OFF_CTRL, ctl(1'b1, 1'b0, CTM_MODE_PGEN, CTM_SRC_DIV0));
        width(1'b0, w);
        check("pulse low width", 32'(w), 32'(p - d));
        width(1'b1, w);
        check("pulse high width", 32'(w), 32'(d));
        apb(1'b1, CTM_OFF_CTRL, ctl(1'b0, 1'b0, CTM_MODE_PGEN, CTM_SRC_DIV0));
        repeat (3) @(posedge core_clk);
        v = pulse_gen_output_pin;
        repeat (40) @(posedge core_clk);
        check("pin held", 32'(pulse_gen_output_pin), 32'(v));
        report_and_stop();
    end
endmodule : test_cascaded_16bit_timer_modes
